// file: sdenv_chk_if.sv
// interface: descriptor, reference and verdict between the top and the limit checker
`timescale 1ns/1ps
interface sdenv_chk_if;
  import sdenv_pkg::*;
  logic [63:0]  desc;
  logic [31:0]  offset;
  logic         fetch;
  logic         write;
  sdenv_mode_e  mode;
  logic         fault;
  logic         exec_fault;
  logic [31:0]  lim_scaled;
  logic [31:0]  addr;

  modport chk (input desc, offset, fetch, write, mode, output fault, exec_fault, lim_scaled, addr);
  modport top (output desc, offset, fetch, write, mode, input fault, exec_fault, lim_scaled, addr);
endinterface

// file: sdenv_limit_chk.sv
// module: combinational run-time integrity check of one legacy reference
`timescale 1ns/1ps
module sdenv_limit_chk (
  sdenv_chk_if.chk c
);
  import sdenv_pkg::*;

  logic [19:0] lim;
  logic [3:0]  seg_type;
  logic [31:0] off;
  logic [31:0] top_off;
  logic        is_code;
  logic        xdown;
  logic        lim_fault;
  logic        rw_fault;
  logic        mode_fault;

  always_comb begin
    lim          = c.desc[F_LIM_LSB +: 20];
    seg_type     = c.desc[F_TYPE_LSB +: 4];
    // granular limits cover whole 4K pages
    c.lim_scaled = c.desc[F_G] ? {lim, GRAN_FILL} : {12'h000, lim};
    // 16-bit segments truncate the effective address
    off          = c.desc[F_DB] ? c.offset : {16'h0000, c.offset[15:0]};
    top_off      = c.desc[F_DB] ? MAX_OFF32 : MAX_OFF16;
    is_code      = seg_type[3];
    xdown        = !is_code && seg_type[2];
    lim_fault    = xdown ? ((off <= c.lim_scaled) || (off > top_off)) : (off > c.lim_scaled);
    // only protected mode insists on an executable code segment
    c.exec_fault = c.fetch && !is_code && (c.mode == MODE_PROT);
    rw_fault     = (c.mode == MODE_PROT) && !c.fetch &&
                   (c.write ? (is_code || !seg_type[1]) : (is_code && !seg_type[1]));
    mode_fault   = c.fetch && (c.mode == MODE_BAD);
    c.fault      = !c.desc[F_S] || !c.desc[F_P] || lim_fault || c.exec_fault || rw_fault || mode_fault;
    c.addr       = c.desc[F_BASE_LSB +: 32] + off;
  end

endmodule // sdenv_limit_chk

// file: sdenv_pkg.sv
// package: constants, segment indices, field positions and modes of the descriptor environment block
// ----------------------------------------------------------------------------
// How it works
// - device keeps no table coherency and never sets accessed bits in memory.
// - native descriptor loads are stored unchecked, accessed bit left as written.
// - instruction set transitions change no base, limit, attribute or privilege.
// - virtual 8086: execute permission faults on the code segment are ignored.
// - granular limit is shifted left 12 with low twelve bits set to ones.
// - integrity checks skipped on transition, applied on legacy fetches and data.
// ----------------------------------------------------------------------------
package sdenv_pkg;

  // ----------------------------------------------------------------------------
  // segment register indices
  // ----------------------------------------------------------------------------
  localparam int unsigned NUM_SEG = 6;
  localparam logic [2:0]  SEG_CS  = 3'h0;
  localparam logic [2:0]  SEG_SS  = 3'h1;
  localparam logic [2:0]  SEG_DS  = 3'h2;
  localparam logic [2:0]  SEG_ES  = 3'h3;
  localparam logic [2:0]  SEG_FS  = 3'h4;
  localparam logic [2:0]  SEG_GS  = 3'h5;

  // ----------------------------------------------------------------------------
  // descriptor field positions
  // ----------------------------------------------------------------------------
  localparam int unsigned F_BASE_LSB = 0;
  localparam int unsigned F_LIM_LSB  = 32;
  localparam int unsigned F_TYPE_LSB = 52;
  localparam int unsigned F_ACC      = 52;
  localparam int unsigned F_S        = 56;
  localparam int unsigned F_DPL_LSB  = 57;
  localparam int unsigned F_P        = 59;
  localparam int unsigned F_AV       = 60;
  localparam int unsigned F_IG       = 61;
  localparam int unsigned F_DB       = 62;
  localparam int unsigned F_G        = 63;
  localparam int unsigned GRAN_SHIFT = 12;

  localparam logic [11:0] GRAN_FILL  = 12'hFFF;
  localparam logic [31:0] MAX_OFF16  = 32'h0000FFFF;
  localparam logic [31:0] MAX_OFF32  = 32'hFFFFFFFF;

  // ----------------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------------
  localparam logic [63:0] DESC_RST   = 64'h0;
  localparam logic [15:0] SEL_RST    = 16'h0;
  localparam logic [1:0]  CPL_RST    = 2'h0;

  // mode encoding is {virtual_8086_flag, protection_enable_bit}
  typedef enum logic [1:0] {
    MODE_REAL = 2'b00,
    MODE_PROT = 2'b01,
    MODE_BAD  = 2'b10,
    MODE_VIRTUAL_8086_MODE = 2'b11
  } sdenv_mode_e;

endpackage

// file: sdenv_sw_model.sv
// model of the native software that sets up descriptors before legacy entry
`timescale 1ns/1ps
module sdenv_sw_model
  import sdenv_pkg::*;
(
  // control
  input  wire logic        sys_clk_i,
  input  wire logic        start_i,
  input  wire sdenv_mode_e mode_i,
  input  wire logic [63:0] raw_i,
  output logic             done_o,
  // native load
  output logic             nat_wr_o,
  output logic [2:0]       nat_seg_o,
  output logic [63:0]      nat_desc_o,
  output logic [15:0]      nat_selector_o,
  output logic             cpl_wr_o,
  output logic [1:0]       cpl_o
);
  logic [15:0] sel;
  logic        pm;
  initial begin
    {done_o, nat_wr_o, cpl_wr_o, nat_seg_o, cpl_o} = '0;
    {nat_desc_o, nat_selector_o} = '0;
  end
  // ----
  // load sequence
  // ----
  always @(posedge start_i) begin
    @(posedge sys_clk_i) #1;
    pm = (mode_i == MODE_PROT);
    cpl_wr_o = 1'b1;
    cpl_o = (mode_i == MODE_VIRTUAL_8086_MODE) ? 2'h3 : 2'h0;
    for (int s = 0; s < 6; s++) begin
      sel = 16'(s + 1) << 12;
      nat_wr_o = 1'b1;
      nat_seg_o = s[2:0];
      nat_selector_o = sel;
      // dpl follows cpl, s/p/a set, data rd/wr expand-up except cs in protected mode (execute/read code), base = selector*16
      nat_desc_o = {pm, pm, 2'b11, 1'b1, cpl_o, 1'b1, (pm && s == 0) ? 4'hB : 4'h3,
                    pm ? 20'h00001 : 20'h0FFFF, 12'h0, sel, 4'h0};
      // breaking the guidelines on purpose: content is never checked on load
      if (mode_i == MODE_BAD)
        nat_desc_o = raw_i;
      @(posedge sys_clk_i) #1;
      cpl_wr_o = 1'b0;
    end
    nat_wr_o = 1'b0;
    nat_desc_o = ~nat_desc_o;
    // done stands until the bench drops start, so it cannot be missed
    done_o = 1'b1;
    wait (start_i == 1'b0);
    done_o = 1'b0;
  end
endmodule // sdenv_sw_model

// file: sdenv_top.sv
// module: segment descriptor registers, transition handling and legacy reference checks
`timescale 1ns/1ps
module sdenv_top #(
  parameter int unsigned N_SEG = sdenv_pkg::NUM_SEG
) (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  // native descriptor load
  input  wire logic        nat_wr_i,
  input  wire logic [2:0]  nat_seg_i,
  input  wire logic [63:0] nat_desc_i,
  input  wire logic [15:0] nat_selector_i,
  input  wire logic        cpl_wr_i,
  input  wire logic [1:0]  cpl_i,
  // environment and transition
  input  wire logic        virtual_8086_flag_i,
  input  wire logic        protection_enable_bit_i,
  input  wire logic        isa_transition_i,
  input  wire logic        isa_to_legacy_i,
  // legacy reference
  input  wire logic        ref_valid_i,
  input  wire logic [2:0]  ref_seg_i,
  input  wire logic        ref_fetch_i,
  input  wire logic        ref_write_i,
  input  wire logic [31:0] ref_offset_i,
  output logic             ref_done_o,
  output logic             ref_fault_o,
  output logic [31:0]      ref_addr_o,
  // readback
  input  wire logic [2:0]  rd_seg_i,
  output logic [63:0]      rd_desc_o,
  output logic [15:0]      rd_selector_o,
  output logic [1:0]       current_privilege_level_o,
  output logic             in_legacy_o
);
  import sdenv_pkg::*;

  if (N_SEG != NUM_SEG) begin : g_bad_seg_count
    $error("sdenv_top: exactly six segment registers are supported");
  end

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  logic [N_SEG-1:0][63:0] desc;
  logic [N_SEG-1:0][63:0] next_desc;
  logic [N_SEG-1:0][15:0] sel;
  logic [N_SEG-1:0][15:0] next_sel;
  logic [1:0]             cpl;
  logic [1:0]             next_cpl;
  logic                   in_legacy;
  logic                   next_in_legacy;
  logic                   next_ref_done;
  logic                   next_ref_fault;
  logic [31:0]            next_ref_addr;
  logic [63:0]            next_rd_desc;
  logic [15:0]            next_rd_selector;
  logic                   ref_take;
  sdenv_mode_e            mode;

  sdenv_chk_if chk_bus ();

  sdenv_limit_chk u_chk (
    .c (chk_bus.chk)
  );

  assign mode = sdenv_mode_e'({virtual_8086_flag_i, protection_enable_bit_i});
  // checks only run on legacy references, never in the transition cycle
  assign ref_take = ref_valid_i && in_legacy && !isa_transition_i;

  assign chk_bus.desc   = (ref_seg_i < 3'(N_SEG)) ? desc[ref_seg_i] : DESC_RST;
  assign chk_bus.offset = ref_offset_i;
  assign chk_bus.fetch  = ref_fetch_i;
  assign chk_bus.write  = ref_write_i;
  assign chk_bus.mode   = mode;

  // ----------------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------------
  always_comb begin
    next_desc = desc;
    next_sel  = sel;
    next_cpl  = cpl;
    // stored as written apart from the code and stack software-only bits: no protection check, accessed bit untouched, no table write-back
    for (int i = 0; i < N_SEG; i++) begin
      if (nat_wr_i && (nat_seg_i == 3'(i))) begin
        next_desc[i] = nat_desc_i;
        next_sel[i]  = nat_selector_i;
        // code and stack keep their software-only bits at zero
        if ((3'(i) == SEG_CS) || (3'(i) == SEG_SS)) begin
          next_desc[i][F_AV] = 1'b0;
          next_desc[i][F_IG] = 1'b0;
        end
      end
    end
    if (cpl_wr_i) begin
      next_cpl = cpl_i;
    end
    // a transition only flips the instruction set, descriptors and privilege stay put
    next_in_legacy = isa_transition_i ? isa_to_legacy_i : in_legacy;
    next_ref_done  = ref_take;
    next_ref_fault = ref_take && (chk_bus.fault || (ref_seg_i >= 3'(N_SEG)));
    next_ref_addr  = ref_take ? chk_bus.addr : ref_addr_o;
    next_rd_desc     = (rd_seg_i < 3'(N_SEG)) ? desc[rd_seg_i] : DESC_RST;
    next_rd_selector = (rd_seg_i < 3'(N_SEG)) ? sel[rd_seg_i] : SEL_RST;
  end

  // ----------------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      desc                      <= '{default: DESC_RST};
      sel                       <= '{default: SEL_RST};
      cpl                       <= CPL_RST;
      in_legacy                 <= 1'b0;
      ref_done_o                <= 1'b0;
      ref_fault_o               <= 1'b0;
      ref_addr_o                <= 32'h00000000;
      rd_desc_o                 <= DESC_RST;
      rd_selector_o             <= SEL_RST;
      current_privilege_level_o <= CPL_RST;
      in_legacy_o               <= 1'b0;
    end else begin
      desc                      <= next_desc;
      sel                       <= next_sel;
      cpl                       <= next_cpl;
      in_legacy                 <= next_in_legacy;
      ref_done_o                <= next_ref_done;
      ref_fault_o               <= next_ref_fault;
      ref_addr_o                <= next_ref_addr;
      rd_desc_o                 <= next_rd_desc;
      rd_selector_o             <= next_rd_selector;
      current_privilege_level_o <= next_cpl;
      in_legacy_o               <= next_in_legacy;
    end
  end

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  property p_native_load_raw;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      nat_wr_i && (nat_seg_i == SEG_DS) |=> desc[SEG_DS] == $past(nat_desc_i);
  endproperty
  a_native_load_raw: assert property (p_native_load_raw) else $error("native load altered the descriptor");

  property p_no_accessed_set;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      nat_wr_i && (nat_seg_i < 3'(N_SEG)) && !nat_desc_i[F_ACC] |=> !desc[$past(nat_seg_i)][F_ACC];
  endproperty
  a_no_accessed_set: assert property (p_no_accessed_set) else $error("accessed bit set by hardware");

  property p_transition_keeps;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      isa_transition_i && !nat_wr_i && !cpl_wr_i |=> $stable(desc) && $stable(cpl) && $stable(sel);
  endproperty
  a_transition_keeps: assert property (p_transition_keeps) else $error("transition changed segment state");

  property p_regs_held;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      !nat_wr_i |=> $stable(desc) && $stable(sel);
  endproperty
  a_regs_held: assert property (p_regs_held) else $error("descriptor changed without a native load");

  property p_cpl_held;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      !cpl_wr_i |=> $stable(cpl) && (current_privilege_level_o == cpl);
  endproperty
  a_cpl_held: assert property (p_cpl_held) else $error("privilege changed without a write");

  property p_virtual_8086_mode_no_exec;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      (mode == MODE_VIRTUAL_8086_MODE) |-> !chk_bus.exec_fault;
  endproperty
  a_virtual_8086_mode_no_exec: assert property (p_virtual_8086_mode_no_exec) else $error("execute fault raised in virtual 8086");

  sequence s_gran_edge_read;
    ref_take && !ref_fetch_i && !ref_write_i && chk_bus.desc[F_G] && chk_bus.desc[F_DB] &&
    chk_bus.desc[F_S] && chk_bus.desc[F_P] && !chk_bus.desc[F_TYPE_LSB+3] && !chk_bus.desc[F_TYPE_LSB+2] &&
    (ref_seg_i < 3'(N_SEG)) && (mode != MODE_BAD);
  endsequence

  property p_gran_top_ok;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      s_gran_edge_read and (ref_offset_i == {chk_bus.desc[F_LIM_LSB +: 20], GRAN_FILL}) |=> ref_done_o && !ref_fault_o;
  endproperty
  a_gran_top_ok: assert property (p_gran_top_ok) else $error("last byte of granular limit faulted");

  property p_gran_past_top;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      s_gran_edge_read and (chk_bus.desc[F_LIM_LSB +: 20] != 20'hFFFFF) and
      (ref_offset_i == {chk_bus.desc[F_LIM_LSB +: 20] + 20'h00001, 12'h000}) |=> ref_fault_o;
  endproperty
  a_gran_past_top: assert property (p_gran_past_top) else $error("offset past granular limit not faulted");

  property p_skip_on_transition;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      isa_transition_i || !in_legacy |=> !ref_done_o && !ref_fault_o;
  endproperty
  a_skip_on_transition: assert property (p_skip_on_transition) else $error("check ran outside legacy execution");

  property p_ref_checked;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      ref_valid_i && in_legacy_o && !isa_transition_i |=> ref_done_o;
  endproperty
  a_ref_checked: assert property (p_ref_checked) else $error("legacy reference was not checked");

  property p_fault_needs_done;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      ref_fault_o |-> ref_done_o;
  endproperty
  a_fault_needs_done: assert property (p_fault_needs_done) else $error("fault shown without a checked reference");

  property p_addr_holds;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      !ref_take |=> $stable(ref_addr_o);
  endproperty
  a_addr_holds: assert property (p_addr_holds) else $error("address moved without a checked reference");

  c_fault_seen:   cover property (@(posedge sys_clk_i) disable iff (!resetn_i) ref_done_o && ref_fault_o);
  c_clean_ref:    cover property (@(posedge sys_clk_i) disable iff (!resetn_i) ref_done_o && !ref_fault_o);
  c_virtual_8086_mode_fetch:   cover property (@(posedge sys_clk_i) disable iff (!resetn_i) ref_take && ref_fetch_i && mode == MODE_VIRTUAL_8086_MODE);
  c_enter_legacy: cover property (@(posedge sys_clk_i) disable iff (!resetn_i) isa_transition_i && isa_to_legacy_i);

endmodule // sdenv_top

// file: testbench.sv
// self-checking bench of the descriptor environment block
`timescale 1ns/1ps
module testbench;
  import sdenv_pkg::*;
  logic sys_clk_i = 1'b0, resetn_i = 1'b0, nat_wr, cpl_wr, vm = 1'b0, pe = 1'b0;
  logic isa_tr = 1'b0, isa_to = 1'b0, ref_valid = 1'b0, ref_fetch = 1'b0, ref_write = 1'b0;
  logic [2:0] nat_seg, ref_seg = 3'h0, rd_seg = 3'h0;
  logic [63:0] nat_desc, rd_desc, raw = 64'h0;
  logic [15:0] nat_sel, rd_sel;
  logic [1:0] cpl, cpl_o, exp_cpl;
  logic [31:0] ref_offset = 32'h0, ref_addr, rng = 32'h2B6204B0;
  logic ref_done, ref_fault, in_legacy, start = 1'b0, sw_done;
  logic [63:0] exp_desc [6] = '{default: 64'h0};
  logic [15:0] exp_sel [6] = '{default: 16'h0};
  sdenv_mode_e mode = MODE_REAL;
  sdenv_mode_e mlist [4] = '{MODE_REAL, MODE_PROT, MODE_BAD, MODE_VIRTUAL_8086_MODE};
  int fails = 0, compares = 0, n;
  always #5 sys_clk_i = ~sys_clk_i;
  sdenv_top u_sdenv_top (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .nat_wr_i(nat_wr), .nat_seg_i(nat_seg),
    .nat_desc_i(nat_desc), .nat_selector_i(nat_sel), .cpl_wr_i(cpl_wr), .cpl_i(cpl),
    .virtual_8086_flag_i(vm), .protection_enable_bit_i(pe), .isa_transition_i(isa_tr), .isa_to_legacy_i(isa_to),
    .ref_valid_i(ref_valid), .ref_seg_i(ref_seg), .ref_fetch_i(ref_fetch), .ref_write_i(ref_write),
    .ref_offset_i(ref_offset), .ref_done_o(ref_done), .ref_fault_o(ref_fault), .ref_addr_o(ref_addr),
    .rd_seg_i(rd_seg), .rd_desc_o(rd_desc), .rd_selector_o(rd_sel), .current_privilege_level_o(cpl_o),
    .in_legacy_o(in_legacy));
  sdenv_sw_model u_sdenv_sw_model (.sys_clk_i(sys_clk_i), .start_i(start), .mode_i(mode), .raw_i(raw),
    .done_o(sw_done), .nat_wr_o(nat_wr), .nat_seg_o(nat_seg), .nat_desc_o(nat_desc),
    .nat_selector_o(nat_sel), .cpl_wr_o(cpl_wr), .cpl_o(cpl));
  // ----
  // expectations
  // ----
  // code and stack keep no software bits, all else stored as written
  always @(posedge sys_clk_i) begin
    if (nat_wr === 1'b1 && nat_seg < 3'h6) begin
      exp_desc[nat_seg] <= nat_desc & ((nat_seg < 3'h2) ? ~64'h3000000000000000 : ~64'h0);
      exp_sel[nat_seg] <= nat_sel;
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [32:0] exp_ref(input logic [63:0] d, input logic [31:0] o,
                                          input sdenv_mode_e m, input logic f, input logic w);
    logic [31:0] lim, off, top;
    logic code, xd, lf, pf;
    lim = d[63] ? {d[51:32], 12'hFFF} : {12'h0, d[51:32]};
    off = d[62] ? o : {16'h0, o[15:0]};
    top = d[62] ? 32'hFFFFFFFF : 32'h0000FFFF;
    code = d[55];
    // expand-down data lives above its limit, up to the top of its size
    xd = !code && d[54];
    lf = xd ? ((off <= lim) || (off > top)) : (off > lim);
    // type only matters in protected mode: fetch needs code, write needs writable data
    pf = (m == MODE_PROT) && (f ? !code : (w ? (code || !d[53]) : (code && !d[53])));
    return {!d[56] || !d[59] || lf || pf || (m == MODE_BAD && f), d[31:0] + off};
  endfunction
  // ----
  // tasks
  // ----
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic summarize();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic rd_all();
    for (int s = 0; s < 6; s++) begin
      rd_seg = s[2:0];
      @(posedge sys_clk_i) #1;
      chk("rd_desc", exp_desc[s], rd_desc);
      chk("rd_selector", {48'h0, exp_sel[s]}, {48'h0, rd_sel});
    end
  endtask
  // valid stays high between calls so references run back to back
  task automatic do_ref(input logic [2:0] s, input logic f, input logic w, input logic [31:0] o);
    logic [32:0] e;
    e = exp_ref(exp_desc[s], o, mode, f, w);
    ref_valid = 1'b1;
    ref_seg = s;
    ref_fetch = f;
    ref_write = w;
    ref_offset = o;
    @(posedge sys_clk_i) #1;
    chk("ref_done", 1, ref_done);
    chk("ref_fault", e[32], ref_fault);
    chk("ref_addr", e[31:0], ref_addr);
  endtask
  task automatic xfer(input logic to);
    isa_tr = 1'b1;
    isa_to = to;
    ref_valid = 1'b1;
    @(posedge sys_clk_i) #1;
    isa_tr = 1'b0;
    ref_valid = 1'b0;
    chk("in_legacy", to, in_legacy);
    chk("ref_done", 0, ref_done);
    chk("cpl", exp_cpl, cpl_o);
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    repeat (4) @(posedge sys_clk_i);
    #1 resetn_i = 1'b1;
    chk("rst_desc", 0, rd_desc);
    chk("rst_legacy", 0, in_legacy);
    foreach (mlist[i]) begin
      mode = mlist[i];
      {vm, pe} = mode;
      rng = xs(rng);
      raw = {rng, ~rng};
      start = 1'b1;
      n = 0;
      while (sw_done !== 1'b1 && n < 50) begin
        @(posedge sys_clk_i) #1;
        n++;
      end
      start = 1'b0;
      if (n == 50) begin
        fails++;
        summarize();
      end
      exp_cpl = (mode == MODE_VIRTUAL_8086_MODE) ? 2'h3 : 2'h0;
      rd_all();
      chk("cpl", exp_cpl, cpl_o);
      // the illegal mode runs references too: its code fetches must fault
      xfer(1'b1);
      rd_all();
      do_ref(SEG_SS, 1'b0, 1'b0, 32'h1FFF);
      do_ref(SEG_SS, 1'b0, 1'b0, 32'h2000);
      do_ref(SEG_SS, 1'b0, 1'b1, 32'h1FFF);
      do_ref(SEG_CS, 1'b1, 1'b0, 32'h10);
      for (int k = 0; k < 24; k++) begin
        rng = xs(rng);
        do_ref(rng[2:0] % 3'h6, rng[3], rng[4] & ~rng[3],
               (mode == MODE_PROT) ? {18'h0, rng[17:4]} : rng);
      end
      ref_valid = 1'b0;
      @(posedge sys_clk_i) #1;
      xfer(1'b0);
      $display("test mode %0d done", mode);
    end
    // reset in mid-run while legacy code runs with privilege 3
    xfer(1'b1);
    resetn_i = 1'b0;
    @(posedge sys_clk_i) #1;
    chk("rst_legacy", 0, in_legacy);
    chk("rst_cpl", 0, cpl_o);
    chk("rst_addr", 0, ref_addr);
    resetn_i = 1'b1;
    rd_seg = SEG_SS;
    @(posedge sys_clk_i) #1;
    chk("rst_desc", 0, rd_desc);
    chk("rst_selector", 0, {48'h0, rd_sel});
    $display("test mid-run reset done");
    summarize();
  end
endmodule // testbench
